// ---- src/ifeb_defs.vh ----
`ifndef IFEB_DEFS_VH
`define IFEB_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IFEB_OFS_FLAGS_4        12'h000
`define IFEB_OFS_ENABLE_0       12'h004
`define IFEB_OFS_ENABLE_1       12'h008
`define IFEB_OFS_ENABLE_2       12'h00c
`define IFEB_OFS_ENABLE_3       12'h010
`define IFEB_OFS_ENABLE_4       12'h014

// ****************************************************************
// Field positions, flag register 4
// ****************************************************************
`define IFEB_F4_CHARGE_TIME     13
`define IFEB_F4_SERIAL_ERROR    1
`define IFEB_F4_PWM_FAULT_B     0

// ****************************************************************
// Field positions, enable register 0
// ****************************************************************
`define IFEB_E0_CONVERTER_DONE  13
`define IFEB_E0_SERIAL_TX       12
`define IFEB_E0_SERIAL_RX       11
`define IFEB_E0_SPI_EVENT       10
`define IFEB_E0_SPI_ERROR       9
`define IFEB_E0_TIMER_THREE     8
`define IFEB_E0_TIMER_TWO       7
`define IFEB_E0_COMPARE_TWO     6
`define IFEB_E0_CAPTURE_TWO     5
`define IFEB_E0_TIMER_ONE       3
`define IFEB_E0_COMPARE_ONE     2
`define IFEB_E0_CAPTURE_ONE     1
`define IFEB_E0_EXT_INPUT_ZERO  0

// ****************************************************************
// Field positions, enable registers 1 to 4
// ****************************************************************
`define IFEB_E1_EXT_INPUT_TWO   13
`define IFEB_E1_TIMER_FIVE      12
`define IFEB_E1_TIMER_FOUR      11
`define IFEB_E1_EXT_INPUT_ONE   4
`define IFEB_E1_CHANGE_NOTIFY   3
`define IFEB_E1_COMPARATOR      2
`define IFEB_E1_I2C_MASTER      1
`define IFEB_E1_I2C_SLAVE       0
`define IFEB_E2_CAPTURE_THREE   5
`define IFEB_E3_PWM_FAULT_A     15
`define IFEB_E3_REAL_TIME_CLOCK 14
`define IFEB_E3_PWM_PERIOD      9
`define IFEB_E4_CHARGE_TIME     13
`define IFEB_E4_SERIAL_ERROR    1
`define IFEB_E4_PWM_FAULT_B     0

// ****************************************************************
// Implemented bit masks and reset value
// ****************************************************************
`define IFEB_MASK_F4_BASE       16'h2002
`define IFEB_MASK_F4_MC         16'h0001
`define IFEB_MASK_E0            16'h3fef
`define IFEB_MASK_E1_BASE       16'h201f
`define IFEB_MASK_E1_LARGE      16'h1800
`define IFEB_MASK_E2            16'h0020
`define IFEB_MASK_E3_BASE       16'h4000
`define IFEB_MASK_E3_MC         16'h8200
`define IFEB_MASK_E4_BASE       16'h2002
`define IFEB_MASK_E4_MC         16'h0001
`define IFEB_RESET_VALUE        16'h0000

`endif

// ---- src/ifeb_rst_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module ifeb_rst_sync
(
	input  wire clk_i,
	input  wire arst_n_i,
	output wire rst_n_o
);

	reg meta_r;
	reg sync_r;

	// ****************************************************************
	// Asynchronous assert, two-stage release
	// ****************************************************************
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= 1'b1;
			sync_r <= meta_r;
		end
	end

	assign rst_n_o = sync_r;

endmodule
`default_nettype wire

// ---- src/ifeb_bit_reg.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ifeb_defs.vh"
module ifeb_bit_reg
#(
	parameter        WIDTH = 16,
	parameter [15:0] MASK  = 16'hffff
)
(
	input  wire             clk_i,
	input  wire             rst_n_i,
	input  wire             wr_i,
	input  wire [WIDTH-1:0] wdata_i,
	input  wire [WIDTH-1:0] lane_i,
	input  wire [WIDTH-1:0] set_i,
	output wire [WIDTH-1:0] q_o
);

	reg  [WIDTH-1:0] bits_r;
	wire [WIDTH-1:0] bits_nxt;
	wire [WIDTH-1:0] mask_w;

	assign mask_w = MASK[WIDTH-1:0];

	// ****************************************************************
	// Write per lane, hardware set beats a clear
	// ****************************************************************
	assign bits_nxt = ((wr_i ? ((wdata_i & lane_i) | (bits_r & ~lane_i)) : bits_r)
		| set_i) & mask_w;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			bits_r <= `IFEB_RESET_VALUE;
		else
			bits_r <= bits_nxt;
	end

	assign q_o = bits_r;

endmodule
`default_nettype wire

// ---- src/ifeb_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ifeb_defs.vh"
module ifeb_top
#(
	parameter MOTOR_CONTROL = 1,
	parameter LARGE_MEMORY  = 1
)
(
	input  wire        CLOCK_I,
	input  wire        ARST_N_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	input  wire [3:0]  PSTRB_I,
	output wire [31:0] PRDATA_O,
	output wire        PREADY_O,
	output wire        PSLVERR_O,
	input  wire        CHARGE_TIME_EVT_I,
	input  wire        SERIAL_ERROR_EVT_I,
	input  wire        PWM_FAULT_B_EVT_I,
	output wire [15:0] FLAGS_4_O,
	output wire [15:0] ENABLE_0_O,
	output wire [15:0] ENABLE_1_O,
	output wire [15:0] ENABLE_2_O,
	output wire [15:0] ENABLE_3_O,
	output wire [15:0] ENABLE_4_O,
	output wire        CHARGE_TIME_REQ_O,
	output wire        SERIAL_ERROR_REQ_O,
	output wire        PWM_FAULT_B_REQ_O
);

	// ****************************************************************
	// Variant masks
	// ****************************************************************
	localparam [15:0] MASK_F4 = `IFEB_MASK_F4_BASE
		| (MOTOR_CONTROL ? `IFEB_MASK_F4_MC : 16'h0000);
	localparam [15:0] MASK_E0 = `IFEB_MASK_E0;
	localparam [15:0] MASK_E1 = `IFEB_MASK_E1_BASE
		| (LARGE_MEMORY ? `IFEB_MASK_E1_LARGE : 16'h0000);
	localparam [15:0] MASK_E2 = `IFEB_MASK_E2;
	localparam [15:0] MASK_E3 = `IFEB_MASK_E3_BASE
		| (MOTOR_CONTROL ? `IFEB_MASK_E3_MC : 16'h0000);
	localparam [15:0] MASK_E4 = `IFEB_MASK_E4_BASE
		| (MOTOR_CONTROL ? `IFEB_MASK_E4_MC : 16'h0000);

	wire        rst_n;
	wire [15:0] lane;
	wire        access_ok;
	wire        setup;
	wire        wr_any;
	wire        hit_f4;
	wire        hit_e0;
	wire        hit_e1;
	wire        hit_e2;
	wire        hit_e3;
	wire        hit_e4;
	wire        hit_any;
	wire [15:0] set_f4;
	wire [15:0] flags_4;
	wire [15:0] enable_0;
	wire [15:0] enable_1;
	wire [15:0] enable_2;
	wire [15:0] enable_3;
	wire [15:0] enable_4;
	reg  [15:0] rd_sel;
	reg         pready_r;
	reg  [31:0] prdata_r;
	reg         pslverr_r;
	reg  [15:0] flags_4_r;
	reg  [15:0] enable_0_r;
	reg  [15:0] enable_1_r;
	reg  [15:0] enable_2_r;
	reg  [15:0] enable_3_r;
	reg  [15:0] enable_4_r;
	reg         charge_time_req_r;
	reg         serial_error_req_r;
	reg         pwm_fault_b_req_r;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	ifeb_rst_sync u_rst_sync
	(
		.clk_i    (CLOCK_I),
		.arst_n_i (ARST_N_I),
		.rst_n_o  (rst_n)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign setup     = PSEL_I & ~PENABLE_I;
	assign access_ok = PSEL_I & PENABLE_I & pready_r;
	assign hit_f4    = (PADDR_I == `IFEB_OFS_FLAGS_4);
	assign hit_e0    = (PADDR_I == `IFEB_OFS_ENABLE_0);
	assign hit_e1    = (PADDR_I == `IFEB_OFS_ENABLE_1);
	assign hit_e2    = (PADDR_I == `IFEB_OFS_ENABLE_2);
	assign hit_e3    = (PADDR_I == `IFEB_OFS_ENABLE_3);
	assign hit_e4    = (PADDR_I == `IFEB_OFS_ENABLE_4);
	assign hit_any   = hit_f4 | hit_e0 | hit_e1 | hit_e2 | hit_e3 | hit_e4;
	assign wr_any    = access_ok & PWRITE_I;
	assign lane      = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

	always @*
	begin
		rd_sel = 16'h0000;
		case (1'b1)
			hit_f4:  rd_sel = flags_4;
			hit_e0:  rd_sel = enable_0;
			hit_e1:  rd_sel = enable_1;
			hit_e2:  rd_sel = enable_2;
			hit_e3:  rd_sel = enable_3;
			hit_e4:  rd_sel = enable_4;
			default: rd_sel = 16'h0000;
		endcase
	end

	// ****************************************************************
	// APB answer, one wait-free access phase
	// ****************************************************************
	always @(posedge CLOCK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r  <= setup;
			pslverr_r <= setup & ~hit_any;
			if (setup & ~PWRITE_I)
				prdata_r <= {16'h0000, rd_sel};
			else if (access_ok)
				prdata_r <= 32'h00000000;
		end
	end

	// ****************************************************************
	// Flag register 4
	// ****************************************************************
	assign set_f4 = {2'b00, CHARGE_TIME_EVT_I, 11'h000,
		SERIAL_ERROR_EVT_I, PWM_FAULT_B_EVT_I};

	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_F4)) u_flags_4
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_f4),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (set_f4),
		.q_o     (flags_4)
	);

	// ****************************************************************
	// Enable registers 0 to 4
	// ****************************************************************
	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_E0)) u_enable_0
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_e0),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (16'h0000),
		.q_o     (enable_0)
	);

	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_E1)) u_enable_1
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_e1),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (16'h0000),
		.q_o     (enable_1)
	);

	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_E2)) u_enable_2
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_e2),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (16'h0000),
		.q_o     (enable_2)
	);

	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_E3)) u_enable_3
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_e3),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (16'h0000),
		.q_o     (enable_3)
	);

	ifeb_bit_reg #(.WIDTH(16), .MASK(MASK_E4)) u_enable_4
	(
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.wr_i    (wr_any & hit_e4),
		.wdata_i (PWDATA_I[15:0]),
		.lane_i  (lane),
		.set_i   (16'h0000),
		.q_o     (enable_4)
	);

	// ****************************************************************
	// Output stage and gated requests
	// ****************************************************************
	always @(posedge CLOCK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_4_r          <= `IFEB_RESET_VALUE;
			enable_0_r         <= `IFEB_RESET_VALUE;
			enable_1_r         <= `IFEB_RESET_VALUE;
			enable_2_r         <= `IFEB_RESET_VALUE;
			enable_3_r         <= `IFEB_RESET_VALUE;
			enable_4_r         <= `IFEB_RESET_VALUE;
			charge_time_req_r  <= 1'b0;
			serial_error_req_r <= 1'b0;
			pwm_fault_b_req_r  <= 1'b0;
		end
		else
		begin
			flags_4_r          <= flags_4;
			enable_0_r         <= enable_0;
			enable_1_r         <= enable_1;
			enable_2_r         <= enable_2;
			enable_3_r         <= enable_3;
			enable_4_r         <= enable_4;
			charge_time_req_r  <= flags_4[`IFEB_F4_CHARGE_TIME]
				& enable_4[`IFEB_E4_CHARGE_TIME];
			serial_error_req_r <= flags_4[`IFEB_F4_SERIAL_ERROR]
				& enable_4[`IFEB_E4_SERIAL_ERROR];
			pwm_fault_b_req_r  <= flags_4[`IFEB_F4_PWM_FAULT_B]
				& enable_4[`IFEB_E4_PWM_FAULT_B];
		end
	end

	assign PRDATA_O           = prdata_r;
	assign PREADY_O           = pready_r;
	assign PSLVERR_O          = pslverr_r;
	assign FLAGS_4_O          = flags_4_r;
	assign ENABLE_0_O         = enable_0_r;
	assign ENABLE_1_O         = enable_1_r;
	assign ENABLE_2_O         = enable_2_r;
	assign ENABLE_3_O         = enable_3_r;
	assign ENABLE_4_O         = enable_4_r;
	assign CHARGE_TIME_REQ_O  = charge_time_req_r;
	assign SERIAL_ERROR_REQ_O = serial_error_req_r;
	assign PWM_FAULT_B_REQ_O  = pwm_fault_b_req_r;

endmodule
`default_nettype wire

// ---- test/ifeb_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module ifeb_props
#(
	parameter MOTOR_CONTROL = 1
)
(
	input wire logic        CLOCK_I,
	input wire logic        ARST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0]  PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        CHARGE_TIME_EVT_I,
	input wire logic [15:0] FLAGS_4_O,
	input wire logic [15:0] ENABLE_4_O,
	input wire logic        CHARGE_TIME_REQ_O,
	input wire logic        SERIAL_ERROR_REQ_O,
	input wire logic        PWM_FAULT_B_REQ_O
);
	localparam [15:0] M4 = MOTOR_CONTROL ? 16'h2003 : 16'h2002;
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (!ARST_N_I);
	a_req_gate:
	assert property ({CHARGE_TIME_REQ_O, SERIAL_ERROR_REQ_O, PWM_FAULT_B_REQ_O} == {FLAGS_4_O[13]
		& ENABLE_4_O[13], FLAGS_4_O[1] & ENABLE_4_O[1], FLAGS_4_O[0] & ENABLE_4_O[0]})
		else $error("request differs from flag and enable");
	a_unimpl_zero:
	assert property (((FLAGS_4_O | ENABLE_4_O) & ~M4) == 16'h0000)
		else $error("unimplemented bit set");
	a_ready_pulse:
	assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
		else $error("ready not a one cycle answer");
	a_ready_access:
	assert property (PREADY_O |-> PSEL_I && PENABLE_I)
		else $error("ready outside access phase");
	a_unmapped_err:
	assert property (PSEL_I && !PENABLE_I && PADDR_I > 12'h014 |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_event_sets:
	assert property (CHARGE_TIME_EVT_I |=> ##1 FLAGS_4_O[13])
		else $error("event did not set flag");
	a_write_en4:
	assert property (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == 12'h014
		&& PSTRB_I[1:0] == 2'b11 |=> ##1 {16'h0, ENABLE_4_O} == ($past(PWDATA_I, 2) & {16'h0, M4}))
		else $error("enable 4 write wrong");
	a_reset_clear:
	assert property ($rose(ARST_N_I) |-> FLAGS_4_O == 16'h0 && ENABLE_4_O == 16'h0)
		else $error("registers not clear after reset");
endmodule
bind ifeb_top ifeb_props #(.MOTOR_CONTROL(MOTOR_CONTROL)) u_props (
	.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.CHARGE_TIME_EVT_I(CHARGE_TIME_EVT_I), .FLAGS_4_O(FLAGS_4_O), .ENABLE_4_O(ENABLE_4_O),
	.CHARGE_TIME_REQ_O(CHARGE_TIME_REQ_O), .SERIAL_ERROR_REQ_O(SERIAL_ERROR_REQ_O),
	.PWM_FAULT_B_REQ_O(PWM_FAULT_B_REQ_O)
);
`default_nettype wire

// ---- test/ifeb_event_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module ifeb_event_src
(
	input  wire logic       clk_i,
	input  wire logic [2:0] fire_i,
	output var  logic [2:0] evt_o
);
	// One cycle event pulses, same clock
	always @(posedge clk_i)
		evt_o <= fire_i;
endmodule
`default_nettype wire

// ---- test/test_interrupt_flag_enable_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ifeb_defs.vh"
module test_interrupt_flag_enable_bank;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [2:0]  fire = 3'b000;
	wire  [2:0]  evt;
	wire  [2:0]  req;
	wire  [15:0] ro [0:5];
	wire  [31:0] prdata;
	wire  [31:0] prdata_sm;
	wire         pready;
	wire         pslverr;
	logic [31:0] rd;
	logic [31:0] rd_sm;
	logic        er;
	logic [15:0] d;
	int          i;
	int          k;
	int          miscompares = 0;
	int          comparisons = 0;

	always #25 clk = ~clk;

	ifeb_event_src u_src (.clk_i(clk), .fire_i(fire), .evt_o(evt));
	ifeb_top #(.MOTOR_CONTROL(1), .LARGE_MEMORY(1)) dut (.CLOCK_I(clk), .ARST_N_I(arst_n),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .CHARGE_TIME_EVT_I(evt[2]), .SERIAL_ERROR_EVT_I(evt[1]),
		.PWM_FAULT_B_EVT_I(evt[0]), .FLAGS_4_O(ro[0]), .ENABLE_0_O(ro[1]), .ENABLE_1_O(ro[2]),
		.ENABLE_2_O(ro[3]), .ENABLE_3_O(ro[4]), .ENABLE_4_O(ro[5]), .CHARGE_TIME_REQ_O(req[2]),
		.SERIAL_ERROR_REQ_O(req[1]), .PWM_FAULT_B_REQ_O(req[0]));

	// Small variant: no motor-control or large-memory bits
	ifeb_top #(.MOTOR_CONTROL(0), .LARGE_MEMORY(0)) dut_small (.CLOCK_I(clk), .ARST_N_I(arst_n),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata_sm), .PREADY_O(),
		.PSLVERR_O(), .CHARGE_TIME_EVT_I(evt[2]), .SERIAL_ERROR_EVT_I(evt[1]),
		.PWM_FAULT_B_EVT_I(evt[0]), .FLAGS_4_O(), .ENABLE_0_O(), .ENABLE_1_O(),
		.ENABLE_2_O(), .ENABLE_3_O(), .ENABLE_4_O(), .CHARGE_TIME_REQ_O(),
		.SERIAL_ERROR_REQ_O(), .PWM_FAULT_B_REQ_O());

	// ****************************************
	// Report and compare
	// ****************************************
	task end_sim;
	begin
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
	begin
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	end
	endtask

	function automatic logic [15:0] msk(input int j, input logic full);
		case (j)
			0: msk = full ? 16'h2003 : 16'h2002;
			1: msk = 16'h3fef;
			2: msk = full ? 16'h381f : 16'h201f;
			3: msk = 16'h0020;
			4: msk = full ? 16'hc200 : 16'h4000;
			default: msk = full ? 16'h2003 : 16'h2002;
		endcase
	endfunction

	// ****************************************
	// Bus transfer, events fire in access cycle
	// ****************************************
	task apb(input logic w, input logic [11:0] a, input logic [15:0] v, input logic [2:0] f);
		int n;
	begin
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'($urandom()), v};
		fire <= f;
		@(posedge clk);
		penable <= 1'b1;
		fire <= 3'b000;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1)
		begin
			miscompares++;
			end_sim;
		end
		else
		begin
			rd = prdata;
			rd_sm = prdata_sm;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	end
	endtask

	task rst_chk;
	begin
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (k = 0; k < 6; k++)
		begin
			apb(1'b0, 12'(k * 4), 16'h0, 3'b000);
			chk("reset value", 32'h0, rd);
			chk("reset copy", 32'h0, {16'h0, ro[k]});
		end
	end
	endtask

	initial
	begin
		void'($urandom(32'h04cb812a));
		rst_chk;
		for (i = 0; i < 30; i++)
		begin
			d = (i < 6) ? 16'hffff : 16'($urandom());
			k = (i < 6) ? i : $urandom_range(5);
			apb(1'b1, 12'(k * 4), d, 3'b000);
			apb(1'b0, 12'(k * 4), 16'h0, 3'b000);
			chk("readback", {16'h0, d & msk(k, 1'b1)}, rd);
			chk("variant readback", {16'h0, d & msk(k, 1'b0)}, rd_sm);
			chk("copy", {16'h0, d & msk(k, 1'b1)}, {16'h0, ro[k]});
			chk("mapped err", 32'h0, {31'h0, er});
		end
		apb(1'b1, 12'h018, 16'hffff, 3'b000);
		chk("unmapped err", 32'h1, {31'h0, er});
		apb(1'b0, 12'h018, 16'h0, 3'b000);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 12'h014, 16'h0, 3'b000);
		apb(1'b1, 12'h000, 16'h0, 3'b000);
		apb(1'b1, 12'h004, 16'h0, 3'b111);
		apb(1'b0, 12'h000, 16'h0, 3'b000);
		chk("flags set", 32'h2003, rd);
		chk("variant flags", 32'h2002, rd_sm);
		chk("req masked", 32'h0, {29'h0, req});
		apb(1'b1, 12'h014, 16'hffff, 3'b000);
		apb(1'b0, 12'h000, 16'h0, 3'b000);
		chk("req enabled", 32'h7, {29'h0, req});
		apb(1'b1, 12'h000, 16'h0, 3'b010);
		apb(1'b0, 12'h000, 16'h0, 3'b000);
		chk("set wins", 32'h0002, rd);
		chk("req after clear", 32'h2, {29'h0, req});
		apb(1'b1, 12'h000, 16'h0, 3'b000);
		apb(1'b0, 12'h000, 16'h0, 3'b000);
		chk("flags cleared", 32'h0, rd);
		rst_chk;
		end_sim;
	end
endmodule
`default_nettype wire
